// File: shared/standby_regs.svh
// Purpose: Named constants for the standby controller and its CPU port
// Assumes: Included by bare name from package and design files
// Notes:   Definitions only; no logic lives here
`ifndef STANDBY_REGS_SVH
`define STANDBY_REGS_SVH

// ----------------------------------------------------------------
// Processor clock control register layout
// ----------------------------------------------------------------
`define PCC_STOP_BIT    3
`define PCC_HALT_BIT    2
`define PCC_SEL_MSB     1
`define PCC_RESET       4'h0

// ----------------------------------------------------------------
// Oscillation wait selection (main-clock periods)
// ----------------------------------------------------------------
`define WAIT_CODE_20    3'h0
`define WAIT_CODE_17    3'h3
`define WAIT_CODE_15    3'h5
`define WAIT_CODE_13    3'h7
`define WAIT_CYC_20     21'h10_0000
`define WAIT_CYC_17     21'h02_0000
`define WAIT_CYC_15     21'h00_8000
`define WAIT_CYC_13     21'h00_2000
`define WAIT_W          21

// ----------------------------------------------------------------
// CPU port: clock switch settling and vector delay
// ----------------------------------------------------------------
`define CLK_SWITCH_CYC  4'h8
`define VEC_DELAY       2'h2

// ----------------------------------------------------------------
// Wishbone register map (byte addresses) and fields
// ----------------------------------------------------------------
`define REG_CTRL        5'h00
`define REG_CMD         5'h04
`define REG_IRQ_REQ     5'h08
`define REG_IRQ_EN      5'h0C
`define REG_STATUS      5'h10
`define CTRL_IME        0
`define CTRL_BTM_LSB    1
`define CTRL_SUBCLK     4
`define CTRL_MAINRUN    5
`define CTRL_SEL_LSB    6
`define CMD_STOP        0
`define CMD_HALT        1
`define CTRL_RESET      8'h20
`define IRQ_RESET       8'h00

`endif

// File: shared/standby_pkg.sv
// Purpose: Types shared by the standby controller and its CPU port
// Assumes: standby_regs.svh supplies the widths
// Notes:   All module state is held in the structs below
`include "standby_regs.svh"

package standby_pkg;

	// ----------------------------------------------------------------
	// Standby states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SB_RUN,
		SB_HALT,
		SB_STOP,
		SB_WAIT
	} sb_state_e;

	// ----------------------------------------------------------------
	// State records
	// ----------------------------------------------------------------
	typedef struct packed {
		sb_state_e        st;
		logic [3:0]       processor_clock_control_reg;
		logic [3:0]       s1;
		logic [3:0]       s2;
		logic [3:0]       prev;
		logic [3:0]       edges;
		logic             resume;
		logic             resume_vec;
		logic             wait_go;
		logic             osc_gnd;
	} dev_s;

	typedef struct packed {
		logic             busy;
		logic [`WAIT_W-1:0] cnt;
	} wait_s;

	typedef struct packed {
		logic             ack;
		logic [31:0]      dat;
		logic [7:0]       ctrl;
		logic [7:0]       req;
		logic [7:0]       en;
		logic [3:0]       sw_cnt;
		logic [1:0]       cmd;
		logic             busy;
		logic             nop;
		logic             clk_wr;
		logic             stop_go;
		logic             halt_go;
		logic [1:0]       vec_cnt;
		logic             vector;
	} cpu_s;

endpackage

// File: shared/standby_if.sv
// Purpose: Link between the CPU port and the standby controller
// Assumes: Both ends run on the same ref_clk
// Notes:   Pulses last one ref_clk cycle
`timescale 1ns/10ps

interface standby_if;
	logic       stop_exec;    // Stop instruction executed
	logic       halt_exec;    // Halt instruction executed
	logic       clk_sel_wr;   // Low clock-select bits rewritten
	logic [1:0] clk_sel;
	logic       on_subclk;    // CPU runs from subsystem clock
	logic       main_run;     // Main oscillator enabled by software
	logic       pend_any;     // Some request with its enable set
	logic       interrupt_master_enable;          // Interrupt master enable
	logic [2:0] wait_sel;     // Interval timer mode wait field
	logic [3:0] processor_clock_control_reg;          // Processor clock control value
	logic       cpu_clk_en;
	logic       resume;       // Standby left by interrupt
	logic       resume_vector;
	logic [3:0] ext_edge;     // Ext irq edges: zero, one, two, four

	modport dev (
		input  stop_exec, halt_exec, clk_sel_wr, clk_sel, on_subclk,
		input  main_run, pend_any, interrupt_master_enable, wait_sel,
		output processor_clock_control_reg, cpu_clk_en, resume, resume_vector, ext_edge
	);
	modport cpu (
		output stop_exec, halt_exec, clk_sel_wr, clk_sel, on_subclk,
		output main_run, pend_any, interrupt_master_enable, wait_sel,
		input  processor_clock_control_reg, cpu_clk_en, resume, resume_vector, ext_edge
	);
endinterface

// File: hw/osc_wait_timer.sv
// Purpose: Counts the oscillation settling wait after a stop release
// Assumes: Runs on the main clock, start is a one-cycle pulse
// Notes:   Prohibited codes fall back to the longest wait
`timescale 1ns/10ps
`include "standby_regs.svh"

module osc_wait_timer
	import standby_pkg::*;
#(
	parameter logic [`WAIT_W-1:0] CYC_20 = `WAIT_CYC_20,
	parameter logic [`WAIT_W-1:0] CYC_17 = `WAIT_CYC_17,
	parameter logic [`WAIT_W-1:0] CYC_15 = `WAIT_CYC_15,
	parameter logic [`WAIT_W-1:0] CYC_13 = `WAIT_CYC_13
) (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       ce,
	input  wire logic       start,
	input  wire logic [2:0] code,
	output logic            done
);

	// Longest wait is the safe answer to a bad code
	function automatic logic [`WAIT_W-1:0] wait_len(input logic [2:0] c);
		case (c)
			`WAIT_CODE_17: wait_len = CYC_17;
			`WAIT_CODE_15: wait_len = CYC_15;
			`WAIT_CODE_13: wait_len = CYC_13;
			default:       wait_len = CYC_20;
		endcase
	endfunction

	wait_s q, d;

	// Load on start, count down to one
	always_comb begin
		d = q;
		done = q.busy && (q.cnt == `WAIT_W'(1));
		if (start) begin
			d.busy = 1'b1;
			d.cnt  = wait_len(code);
		end else if (done) begin
			d.busy = 1'b0;
		end else if (q.busy) begin
			d.cnt = q.cnt - `WAIT_W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			q <= '0;
		else if (ce)
			q <= d;
	end

endmodule

// File: hw/standby_ctrl.sv
// Purpose: Stop/halt standby controller gating CPU and peripheral clocks
// Assumes: ref_clk is the main system clock; ext irq pins are async
// Notes:   Register contents are kept by gating enables, never by reset
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`include "standby_regs.svh"

module standby_ctrl
	import standby_pkg::*;
#(
	parameter logic [`WAIT_W-1:0] CYC_20 = `WAIT_CYC_20,
	parameter logic [`WAIT_W-1:0] CYC_17 = `WAIT_CYC_17,
	parameter logic [`WAIT_W-1:0] CYC_15 = `WAIT_CYC_15,
	parameter logic [`WAIT_W-1:0] CYC_13 = `WAIT_CYC_13
) (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic ce,
	standby_if.dev    link,
	input  wire logic ext_irq_zero,
	input  wire logic ext_irq_one,
	input  wire logic ext_irq_two,
	input  wire logic ext_irq_four,
	input  wire logic serial0_ext_sel,
	input  wire logic serial1_ext_sel,
	input  wire logic event_ext_sel,
	input  wire logic watch_sub_sel,
	output logic      main_osc_en,
	output logic      main_osc_input_gnd,
	output logic      interval_timer_en,
	output logic      serial0_en,
	output logic      serial1_en,
	output logic      event_counter_en,
	output logic      watch_timer_en,
	output logic      converter_en,
	output logic      pulse_gen_en,
	output logic      standby_active
);

	// ----------------------------------------------------------------
	// State and helpers
	// ----------------------------------------------------------------
	dev_s q, d;
	logic wait_done;

	// Peripheral enable: stop keeps only externally clocked units,
	// everything else follows the main clock
	function automatic logic periph_run(
		input sb_state_e st,
		input logic      stop_ok,
		input logic      main_ok
	);
		if (st == SB_STOP)
			periph_run = stop_ok;
		else
			periph_run = main_ok;
	endfunction

	// ----------------------------------------------------------------
	// Oscillation wait counter
	// ----------------------------------------------------------------
	// Started on the way out of stop, also when stop met a pending
	// request and the part sat in halt instead
	osc_wait_timer #(
		.CYC_20 (CYC_20),
		.CYC_17 (CYC_17),
		.CYC_15 (CYC_15),
		.CYC_13 (CYC_13)
	) u_wait (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.ce      (ce),
		.start   (q.wait_go),
		.code    (link.wait_sel),
		.done    (wait_done)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		d            = q;
		d.resume     = 1'b0;
		d.wait_go    = 1'b0;

		// Pins pass two flops before anything looks at them
		d.s1   = {ext_irq_four, ext_irq_two, ext_irq_one, ext_irq_zero};
		d.s2   = q.s1;
		d.prev = q.s2;
		d.edges = q.s2 & ~q.prev;
		if (q.st != SB_RUN)
			d.edges[0] = 1'b0;

		// Clock select bits take their new value at once; the CPU
		// side owns the settling time after it
		if (link.clk_sel_wr)
			d.processor_clock_control_reg[`PCC_SEL_MSB:0] = link.clk_sel;

		case (q.st)
			SB_RUN: begin
				// Stop is refused while running on the subclock
				if (link.stop_exec && !link.on_subclk) begin
					d.processor_clock_control_reg[`PCC_STOP_BIT] = 1'b1;
					if (link.pend_any) begin
						// Oscillator never stops; sit in halt and wait
						d.st      = SB_WAIT;
						d.wait_go = 1'b1;
					end else begin
						d.st      = SB_STOP;
						d.osc_gnd = 1'b1;
					end
				end else if (link.halt_exec) begin
					d.processor_clock_control_reg[`PCC_HALT_BIT] = 1'b1;
					d.st                 = SB_HALT;
				end
			end
			SB_HALT: begin
				// A request pending at entry ends halt next cycle
				if (link.pend_any) begin
					d.st                 = SB_RUN;
					d.processor_clock_control_reg[`PCC_HALT_BIT] = 1'b0;
					d.resume             = 1'b1;
					d.resume_vec         = link.interrupt_master_enable;
				end
			end
			SB_STOP: begin
				// Restart oscillator, then settle before the CPU runs
				if (link.pend_any) begin
					d.st      = SB_WAIT;
					d.osc_gnd = 1'b0;
					d.wait_go = 1'b1;
				end
			end
			SB_WAIT: begin
				if (wait_done) begin
					d.st                 = SB_RUN;
					d.processor_clock_control_reg[`PCC_STOP_BIT] = 1'b0;
					d.resume             = 1'b1;
					d.resume_vec         = link.interrupt_master_enable;
				end
			end
			default: begin
				d.st = SB_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset is the only path that clears state, so a reset in
	// standby runs the ordinary reset sequence
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			q     <= '0;
			q.st  <= SB_RUN;
			q.processor_clock_control_reg <= `PCC_RESET;
		end else if (ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Link outputs
	// ----------------------------------------------------------------
	// CPU clock only in run; nothing else is touched, so registers,
	// memory and port latches simply hold
	assign link.cpu_clk_en    = (q.st == SB_RUN);
	assign link.processor_clock_control_reg           = q.processor_clock_control_reg;
	assign link.resume        = q.resume;
	assign link.resume_vector = q.resume_vec;
	assign link.ext_edge      = q.edges;

	// ----------------------------------------------------------------
	// Clock generator and peripheral enables
	// ----------------------------------------------------------------
	// Oscillator runs in the wait state too, which is how a pending
	// stop behaves like halt
	assign main_osc_en        = (q.st != SB_STOP);
	assign main_osc_input_gnd = q.osc_gnd;
	assign standby_active     = (q.st != SB_RUN);

	// Halt and wait need the main clock; stop allows external clocks
	assign interval_timer_en = periph_run(q.st, 1'b0,
		link.main_run);
	assign serial0_en = periph_run(q.st, serial0_ext_sel,
		link.main_run);
	assign serial1_en = periph_run(q.st, serial1_ext_sel,
		link.main_run);
	assign event_counter_en = periph_run(q.st, event_ext_sel,
		link.main_run);
	assign converter_en = periph_run(q.st, 1'b0,
		link.main_run);
	assign pulse_gen_en = periph_run(q.st, 1'b0,
		link.main_run);

	// Watch timer has its own subclock, so halt never stops it
	assign watch_timer_en = periph_run(q.st, watch_sub_sel,
		1'b1);

endmodule

// File: hw/cpu_standby_port.sv
// Purpose: CPU-side end: Wishbone registers, request flags, commands
// Assumes: Classic Wishbone slave, 32-bit, single ref_clk
// Notes:   Stands in for instruction execution and the irq controller
`timescale 1ns/10ps
`include "standby_regs.svh"

module cpu_standby_port
	import standby_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	standby_if.cpu           link,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [3:0]  hw_irq,
	output logic             vector_take
);

	cpu_s q, d;
	logic wr, rd_take;
	logic [7:0] clr;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		d         = q;
		d.clk_wr  = 1'b0;
		d.stop_go = 1'b0;
		d.halt_go = 1'b0;
		d.vector  = 1'b0;
		rd_take   = wb_cyc_i && wb_stb_i && !q.ack;
		d.ack     = rd_take;
		// Writes land on the edge where the master sees ack
		wr        = wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0];
		clr       = '0;

		if (wr) begin
			case (wb_adr_i)
				`REG_CTRL: begin
					d.ctrl   = wb_dat_i[7:0];
					d.clk_wr = 1'b1;
					d.sw_cnt = `CLK_SWITCH_CYC;
				end
				`REG_CMD:     d.cmd = q.cmd | wb_dat_i[1:0];
				`REG_IRQ_REQ: clr = wb_dat_i[7:0];
				`REG_IRQ_EN:  d.en = wb_dat_i[7:0];
				default: begin
				end
			endcase
		end

		// New requests beat a clear in the same cycle
		d.req = (q.req & ~clr) | {hw_irq, link.ext_edge};

		// Read data registered with the ack
		if (rd_take) begin
			case (wb_adr_i)
				`REG_CTRL:    d.dat = {24'h0, q.ctrl};
				`REG_IRQ_REQ: d.dat = {24'h0, q.req};
				`REG_IRQ_EN:  d.dat = {24'h0, q.en};
				`REG_STATUS:  d.dat = {26'h0, q.cmd != 2'h0,
					|(q.req & q.en), link.processor_clock_control_reg[`PCC_STOP_BIT],
					link.processor_clock_control_reg[`PCC_HALT_BIT], q.sw_cnt != 4'h0, q.busy};
				default:      d.dat = 32'h0;
			endcase
		end

		if (q.sw_cnt != 4'h0)
			d.sw_cnt = q.sw_cnt - 4'h1;

		// Issue a command only after the clock has settled
		if (q.cmd != 2'h0 && q.sw_cnt == 4'h0 && !q.busy) begin
			d.stop_go = q.cmd[`CMD_STOP];
			d.halt_go = !q.cmd[`CMD_STOP] && q.cmd[`CMD_HALT];
			d.cmd     = 2'h0;
			d.busy    = 1'b1;
		end

		// Stop refused on subclock: device never enters, so free up
		if (q.stop_go && link.on_subclk)
			d.busy = 1'b0;

		// One idle slot after release stands for the no-op
		if (link.resume) begin
			d.nop = 1'b1;
			if (link.resume_vector)
				d.vec_cnt = `VEC_DELAY;
		end else if (q.nop) begin
			d.nop  = 1'b0;
			d.busy = 1'b0;
		end

		if (q.vec_cnt != 2'h0) begin
			d.vec_cnt = q.vec_cnt - 2'h1;
			d.vector  = (q.vec_cnt == 2'h1);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			q      <= '0;
			q.ctrl <= `CTRL_RESET;
			q.req  <= `IRQ_RESET;
			q.en   <= `IRQ_RESET;
		end else if (ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign wb_ack_o       = q.ack;
	assign wb_dat_o       = q.dat;
	assign vector_take    = q.vector;
	assign link.stop_exec = q.stop_go;
	assign link.halt_exec = q.halt_go;
	assign link.clk_sel_wr = q.clk_wr;
	assign link.clk_sel   = q.ctrl[`CTRL_SEL_LSB+1:`CTRL_SEL_LSB];
	assign link.on_subclk = q.ctrl[`CTRL_SUBCLK];
	assign link.main_run  = q.ctrl[`CTRL_MAINRUN];
	assign link.interrupt_master_enable       = q.ctrl[`CTRL_IME];
	assign link.wait_sel  = q.ctrl[`CTRL_BTM_LSB+2:`CTRL_BTM_LSB];
	assign link.pend_any  = |(q.req & q.en);

endmodule

// File: test/standby_stop_halt_control_chk.sv
// Purpose: Concurrent checks on the link between the two standby ends
// Assumes: One ref_clk domain; resetn asynchronous, active low
// Notes:   Stop-wait bound suits the shortened wait counts of the bench
`timescale 1ns/10ps

module standby_link_chk (
	input wire logic       ref_clk,
	input wire logic       resetn,
	input wire logic       stop_exec,
	input wire logic       halt_exec,
	input wire logic       on_subclk,
	input wire logic       pend_any,
	input wire logic       interrupt_master_enable,
	input wire logic [3:0] processor_clock_control_reg,
	input wire logic       cpu_clk_en,
	input wire logic       resume,
	input wire logic       resume_vector,
	input wire logic [3:0] ext_edge
);
	// Longest shortened wait plus entry and exit slack
	localparam int STOP_MAX = 80;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	AST_STOP_SETS_BIT: assert property (stop_exec && !on_subclk |=> processor_clock_control_reg[3])
		else $error("stop pulse did not set the stop bit");
	AST_HALT_SETS_BIT: assert property (halt_exec |=> processor_clock_control_reg[2] && !cpu_clk_en)
		else $error("halt pulse did not set halt bit and gate cpu clock");
	AST_STOP_REFUSED: assert property (stop_exec && on_subclk |=> !processor_clock_control_reg[3])
		else $error("stop accepted while on subsystem clock");
	AST_CPU_GATED: assert property (|processor_clock_control_reg[3:2] |-> !cpu_clk_en)
		else $error("cpu clock running in standby");
	AST_HALT_EXIT: assert property (processor_clock_control_reg[2] && pend_any |=> !processor_clock_control_reg[2] && resume)
		else $error("halt not left after enabled request");
	AST_HALT_HOLD: assert property (processor_clock_control_reg[2] && !pend_any |=> processor_clock_control_reg[2])
		else $error("halt left without a release cause");
	AST_STOP_MIN: assert property ($rose(processor_clock_control_reg[3]) |=> processor_clock_control_reg[3] [*8])
		else $error("stop left before the oscillation wait");
	AST_STOP_MAX: assert property (processor_clock_control_reg[3] && pend_any |-> ##[1:STOP_MAX] !processor_clock_control_reg[3])
		else $error("stop wait ran past its longest count");
	AST_VECTOR_FLAG: assert property (resume |-> resume_vector == $past(interrupt_master_enable))
		else $error("resume vector flag differs from master enable");
	AST_ZERO_IGNORED: assert property ($past(|processor_clock_control_reg[3:2]) && |processor_clock_control_reg[3:2] |-> !ext_edge[0])
		else $error("ext irq zero edge passed during standby");

	// Main scenarios reached
	cover property ($rose(processor_clock_control_reg[2]));
	cover property ($rose(processor_clock_control_reg[3]));
	cover property (resume && resume_vector);
	cover property (stop_exec && on_subclk);
endmodule

// File: test/standby_stop_halt_control_tb_top.sv
// Purpose: Self-checking bench joining the CPU port and the controller
// Assumes: Wait counts shortened to 64, 32, 16 and 8 cycles
// Notes:   Each scenario is one task that drives and judges itself
`timescale 1ns/10ps
`include "standby_regs.svh"

module standby_stop_halt_control_tb_top
	import standby_pkg::*;
;
	logic        ref_clk  = 1'b0;
	logic        resetn   = 1'b0;
	logic        cyc      = 1'b0;
	logic        stb      = 1'b0;
	logic        we       = 1'b0;
	logic [4:0]  adr      = 5'h00;
	logic [31:0] wdat     = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic [3:0]  hw_irq   = 4'h0;
	logic [3:0]  pins     = 4'h0;   // Ext irq zero, one, two, four
	logic [3:0]  sels     = 4'h0;   // Serial0, serial1, event, watch
	logic        ce       = 1'b1;   // Shared clock enable of both ends
	logic [3:0]  sel      = 4'hF;   // Byte selects of the bus master
	logic        vec;
	logic        sb_act;
	logic [8:0]  en_vec;
	logic [31:0] q;
	int          n_errors = 0;
	int          compares = 0;
	int          cycles   = 0;
	standby_if   link ();

	// ----------------------------------------------------------------
	// Both ends and the checker
	// ----------------------------------------------------------------
	standby_ctrl #(.CYC_20(21'h40), .CYC_17(21'h20), .CYC_15(21'h10),
		.CYC_13(21'h8)) standby_ctrl_inst (.ref_clk(ref_clk),
		.resetn(resetn), .ce(ce), .link(link), .ext_irq_zero(pins[0]),
		.ext_irq_one(pins[1]), .ext_irq_two(pins[2]),
		.ext_irq_four(pins[3]), .serial0_ext_sel(sels[0]),
		.serial1_ext_sel(sels[1]), .event_ext_sel(sels[2]),
		.watch_sub_sel(sels[3]), .main_osc_en(en_vec[8]),
		.main_osc_input_gnd(en_vec[7]), .interval_timer_en(en_vec[6]),
		.serial0_en(en_vec[5]), .serial1_en(en_vec[4]),
		.event_counter_en(en_vec[3]), .watch_timer_en(en_vec[2]),
		.converter_en(en_vec[1]), .pulse_gen_en(en_vec[0]),
		.standby_active(sb_act));
	cpu_standby_port cpu_standby_port_inst (.ref_clk(ref_clk),
		.resetn(resetn), .ce(ce), .link(link), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.hw_irq(hw_irq), .vector_take(vec));
	standby_link_chk standby_link_chk_inst (.ref_clk(ref_clk),
		.resetn(resetn), .stop_exec(link.stop_exec),
		.halt_exec(link.halt_exec), .on_subclk(link.on_subclk),
		.pend_any(link.pend_any), .interrupt_master_enable(link.interrupt_master_enable), .processor_clock_control_reg(link.processor_clock_control_reg),
		.cpu_clk_en(link.cpu_clk_en), .resume(link.resume),
		.resume_vector(link.resume_vector), .ext_edge(link.ext_edge));

	// Clock and hang guard; a hang counts as a mismatch
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		@(posedge ref_clk);
		while (ack !== 1'b1) @(posedge ref_clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic pulse_hw(input logic [3:0] b);
		@(posedge ref_clk);
		hw_irq <= b;
		@(posedge ref_clk);
		hw_irq <= 4'h0;
	endtask

	task automatic complete_run();
		$display("Compares %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		wb(1'b0, `REG_CTRL, 32'h0);
		check("ctrl", 32'h20, q);
		// Write without byte lane zero must leave the register alone
		sel <= 4'hE;
		wb(1'b1, `REG_CTRL, 32'h0);
		sel <= 4'hF;
		wb(1'b0, `REG_CTRL, 32'h0);
		check("masked write", 32'h20, q);
		wb(1'b0, 5'h14, 32'h0);
		check("unmapped", 32'h0, q);
		check("run enables", 32'h17F, en_vec);
	endtask

	// Irq zero must not end halt even though its enable is set
	task automatic t_halt();
		wb(1'b1, `REG_IRQ_EN, 32'h11);
		wb(1'b1, `REG_CMD, 32'h2);
		while (sb_act !== 1'b1) @(posedge ref_clk);
		check("cpu clock", 32'h0, link.cpu_clk_en);
		check("halt enables", 32'h17F, en_vec);
		pins[0] <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check("still halted", 32'h1, sb_act);
		pins[0] <= 1'b0;
		pulse_hw(4'h1);
		while (link.resume !== 1'b1) @(posedge ref_clk);
		check("pcc after halt", 32'h0, link.processor_clock_control_reg);
		wb(1'b0, `REG_IRQ_REQ, 32'h0);
		check("held flag", 32'h10, q);
		wb(1'b1, `REG_IRQ_REQ, 32'hFF);
	endtask

	// Every wait code, each with a different peripheral select
	task automatic t_stop();
		logic [11:0] codes;
		logic [3:0]  rsel;
		int          n;
		codes = {`WAIT_CODE_13, `WAIT_CODE_15, `WAIT_CODE_17, `WAIT_CODE_20};
		for (int i = 0; i < 4; i++) begin
			sels <= 4'h1 << i;
			wb(1'b1, `REG_CTRL, {24'h0, 3'h1, 1'b0, codes[i*3+:3], 1'b0});
			wb(1'b1, `REG_CMD, 32'h1);
			while (link.processor_clock_control_reg[3] !== 1'b1) @(posedge ref_clk);
			// Serial0 sits at the top of the enable field, watch last
			rsel = {sels[0], sels[1], sels[2], sels[3]};
			check("stop enables", {3'h2, rsel, 2'h0}, en_vec);
			n = 0;
			pulse_hw(4'h1);
			while (link.resume !== 1'b1) begin
				@(posedge ref_clk);
				n++;
			end
			check("wait span", 32'h1, n >= (64 >> i) + 2 && n <= (64 >> i) + 9);
			wb(1'b1, `REG_IRQ_REQ, 32'hFF);
		end
		sels <= 4'h0;
	endtask

	// Request already pending: stop acts as halt, oscillator kept on
	task automatic t_pending();
		logic low;
		low = 1'b0;
		wb(1'b1, `REG_CTRL, 32'h2E);
		pulse_hw(4'h1);
		wb(1'b1, `REG_CMD, 32'h1);
		while (link.resume !== 1'b1) begin
			@(posedge ref_clk);
			if (en_vec[8] !== 1'b1)
				low = 1'b1;
		end
		check("osc kept", 32'h0, low);
		wb(1'b1, `REG_IRQ_REQ, 32'hFF);
	endtask

	// Subsystem clock: stop refused, halt taken, irq four releases
	task automatic t_subclk();
		wb(1'b1, `REG_CTRL, 32'h31);
		wb(1'b1, `REG_IRQ_EN, 32'h08);
		wb(1'b1, `REG_CMD, 32'h1);
		repeat (20) @(posedge ref_clk);
		check("stop refused", 32'h0, sb_act);
		wb(1'b1, `REG_CMD, 32'h2);
		while (sb_act !== 1'b1) @(posedge ref_clk);
		pins[3] <= 1'b1;
		while (link.resume !== 1'b1) @(posedge ref_clk);
		check("vector flag", 32'h1, link.resume_vector);
		repeat (3) @(posedge ref_clk);
		check("vector taken", 32'h1, vec);
		pins[3] <= 1'b0;
		wb(1'b1, `REG_IRQ_REQ, 32'hFF);
	endtask

	// Clock enable low freezes both ends, so a pulse then is lost
	task automatic t_freeze();
		wb(1'b1, `REG_IRQ_EN, 32'h10);
		wb(1'b1, `REG_CMD, 32'h2);
		while (sb_act !== 1'b1) @(posedge ref_clk);
		ce <= 1'b0;
		pulse_hw(4'h1);
		ce <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check("frozen halt", 32'h1, sb_act);
		pulse_hw(4'h1);
		while (link.resume !== 1'b1) @(posedge ref_clk);
		check("freeze release", 32'h0, link.processor_clock_control_reg[2]);
		wb(1'b1, `REG_IRQ_REQ, 32'hFF);
	endtask

	// Reset in mid-halt runs the full reset
	task automatic t_reset_mid();
		wb(1'b1, `REG_CMD, 32'h2);
		while (sb_act !== 1'b1) @(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("reset leaves", 32'h0, sb_act);
		resetn <= 1'b1;
		wb(1'b0, `REG_CTRL, 32'h0);
		check("ctrl again", 32'h20, q);
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_halt();
		t_stop();
		t_pending();
		t_subclk();
		t_freeze();
		t_reset_mid();
		complete_run();
	end
endmodule
